// File: design/frac_pkg.sv
// Shared constants and types for the flash region access guard
package frac_pkg;

   // Geometry
   localparam int NUM_REGIONS = 8;
   localparam int ADDR_W = 32;
   localparam int DATA_W = 32;
   localparam int REG_AW = 12;
   localparam int IDX_W = 3;
   localparam int PAGE_LSB = 12;
   localparam logic [31:0] FLASH_PAGE_BYTES = 32'h0000_1000;

   // Region register block
   localparam logic [11:0] REGION_BASE = 12'h800;
   localparam logic [11:0] REGION_END = 12'h880;
   localparam int REGION_IDX_LSB = 4;
   localparam logic [3:0] OFS_START = 4'h0;
   localparam logic [3:0] OFS_SIZE = 4'h4;
   localparam logic [3:0] OFS_REGION_PERMISSION_SETTING = 4'h8;

   // Guard-level registers
   localparam logic [11:0] INT_STATUS = 12'h100;
   localparam logic [11:0] INT_MASK = 12'h104;
   localparam logic [11:0] VIOL_ADDR = 12'h108;
   localparam logic [11:0] VIOL_INFO = 12'h10c;
   localparam logic [11:0] REGION_ACTIVE = 12'h110;

   // Permission field positions
   localparam int REGION_PERMISSION_SETTING_WRITE_BIT = 1;
   localparam int REGION_PERMISSION_SETTING_READ_BIT = 2;
   localparam int REGION_PERMISSION_SETTING_W = 3;

   // Event bits
   localparam int EV_CPU_FAULT = 0;
   localparam int EV_DBG_ZERO = 1;
   localparam int EV_DBG_DROP = 2;
   localparam int NUM_EVENTS = 3;

   // Violation info field positions
   localparam int INFO_KIND_LSB = 0;
   localparam int INFO_SRC_BIT = 2;
   localparam int INFO_CNT_LSB = 16;
   localparam int CNT_W = 16;

   // Timing: enforcement starts this many cycles after the last write
   localparam int CLK_HZ = 20_000_000;
   localparam int ENFORCE_CYCLES = 2;

   // Reset values
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [2:0] RST_EVENTS = 3'h0;
   localparam logic [15:0] RST_CNT = 16'h0000;

   typedef enum logic [1:0] {
      FRAC_EXEC = 2'b00,
      FRAC_READ = 2'b01,
      FRAC_WRITE = 2'b11,
      FRAC_ERASE = 2'b10
   } frac_kind_t;

endpackage

// File: design/frac_region.sv
// One protected flash region: write-once settings and address check
`timescale 1ns/1ps
module frac_region
   import frac_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic wr_start,
   input wire logic wr_size,
   input wire logic wr_region_permission_setting,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic [ADDR_W-1:0] cpu_addr,
   input wire logic [ADDR_W-1:0] dbg_addr,
   output logic [ADDR_W-1:0] start,
   output logic [ADDR_W-1:0] size,
   output logic [REGION_PERMISSION_SETTING_W-1:0] region_permission_setting,
   output logic active,
   output logic cpu_rd_blk,
   output logic cpu_wr_blk,
   output logic dbg_rd_blk,
   output logic dbg_wr_blk
);

   logic start_done;
   logic size_done;
   logic region_permission_setting_done;
   logic cfg_done;
   logic cpu_hit;
   logic dbg_hit;
   logic [ADDR_W:0] limit;

   // Misaligned start is refused and does not use up the single write
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         start <= RST_WORD;
         start_done <= 1'b0;
      end
      else if (wr_start && !start_done && wdata[PAGE_LSB-1:0] == '0)
      begin
         start <= wdata;
         start_done <= 1'b1;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         size <= RST_WORD;
         size_done <= 1'b0;
      end
      else if (wr_size && !size_done && wdata != '0)
      begin
         size <= wdata;
         size_done <= 1'b1;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         region_permission_setting <= '0;
         region_permission_setting_done <= 1'b0;
      end
      else if (wr_region_permission_setting && !region_permission_setting_done && wdata[REGION_PERMISSION_SETTING_W-1:1] != '0)
      begin
         region_permission_setting <= {wdata[REGION_PERMISSION_SETTING_W-1:1], 1'b0};
         region_permission_setting_done <= 1'b1;
      end
   end

   assign cfg_done = start_done && size_done && region_permission_setting_done;

   // Settings land one edge after the strobe; one more stage makes two
   always_ff @(posedge clk)
   begin
      if (rst)
         active <= 1'b0;
      else
         active <= cfg_done;
   end

   assign limit = {1'b0, start} + {1'b0, size};
   assign cpu_hit = active && {1'b0, cpu_addr} >= {1'b0, start} && {1'b0, cpu_addr} < limit;
   assign dbg_hit = active && {1'b0, dbg_addr} >= {1'b0, start} && {1'b0, dbg_addr} < limit;

   // Read bit blocks read and execute, write bit blocks write and erase
   assign cpu_rd_blk = cpu_hit && region_permission_setting[REGION_PERMISSION_SETTING_READ_BIT];
   assign cpu_wr_blk = cpu_hit && region_permission_setting[REGION_PERMISSION_SETTING_WRITE_BIT];
   assign dbg_rd_blk = dbg_hit && region_permission_setting[REGION_PERMISSION_SETTING_READ_BIT];
   assign dbg_wr_blk = dbg_hit && region_permission_setting[REGION_PERMISSION_SETTING_WRITE_BIT];

endmodule

// File: design/frac_guard.sv
// Flash region access guard: region registers, access checks, interrupt
//
// Functional notes
// - Each region has a permission setting, a page-aligned start and a size.
// - Read 0, write 0: every kind of access allowed in the region.
// - Read 0, write 1: execute and read allowed, write and erase blocked.
// - Read 1, write 0: write and erase allowed, execute and read blocked.
// - Both bits 1: all access blocked until the next reset.
// - A violating CPU request is blocked and raises a bus fault.
// - Enforcement begins two cycles after all three settings are written.
// - A region is enforced only with a valid page-aligned start.
// - A region is enforced only with non-zero size and permission.
// - Start, size and permission accept one write each; later writes ignored.
// - Only device reset clears region configuration.
// - Debugger reads of a read-protected region return zero.
// - Debugger writes to a write-protected region are silently dropped.
// - Eight independent regions, numbered zero to seven.
// - Write bit 1 blocks write and erase; 0 allows them.
`timescale 1ns/1ps
module frac_guard
   import frac_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [REG_AW-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [DATA_W-1:0] reg_rdata,
   input wire logic cpu_req,
   input wire frac_kind_t cpu_kind,
   input wire logic [ADDR_W-1:0] cpu_addr,
   output logic cpu_flash_en,
   output logic cpu_bus_fault,
   input wire logic dbg_req,
   input wire logic dbg_write,
   input wire logic [ADDR_W-1:0] dbg_addr,
   output logic dbg_flash_re,
   output logic dbg_flash_we,
   input wire logic [DATA_W-1:0] flash_rdata,
   output logic [DATA_W-1:0] dbg_rdata,
   output logic irq
);

   logic [ADDR_W-1:0] r_start [NUM_REGIONS];
   logic [ADDR_W-1:0] r_size [NUM_REGIONS];
   logic [REGION_PERMISSION_SETTING_W-1:0] r_region_permission_setting [NUM_REGIONS];
   logic [NUM_REGIONS-1:0] r_active;
   logic [NUM_REGIONS-1:0] cpu_rd_blk;
   logic [NUM_REGIONS-1:0] cpu_wr_blk;
   logic [NUM_REGIONS-1:0] dbg_rd_blk;
   logic [NUM_REGIONS-1:0] dbg_wr_blk;
   logic [NUM_REGIONS-1:0] wr_start;
   logic [NUM_REGIONS-1:0] wr_size;
   logic [NUM_REGIONS-1:0] wr_region_permission_setting;

   logic in_region_block;
   logic [IDX_W-1:0] sel_idx;
   logic [3:0] sel_field;

   logic cpu_is_read;
   logic cpu_blocked;
   logic dbg_rd_blocked;
   logic dbg_wr_blocked;

   logic [NUM_EVENTS-1:0] int_status;
   logic [NUM_EVENTS-1:0] int_mask;
   logic [NUM_EVENTS-1:0] events;
   logic [NUM_EVENTS-1:0] next_status;

   logic [ADDR_W-1:0] viol_addr;
   frac_kind_t viol_kind;
   logic viol_src_dbg;
   logic [CNT_W-1:0] viol_cnt;

   logic dbg_zero_q;
   logic dbg_read_q;
   logic [DATA_W-1:0] next_rdata;

   // Region register block decode
   assign in_region_block = reg_addr >= REGION_BASE && reg_addr < REGION_END;
   assign sel_idx = reg_addr[REGION_IDX_LSB +: IDX_W];
   assign sel_field = reg_addr[3:0];

   always_comb
   begin
      wr_start = '0;
      wr_size = '0;
      wr_region_permission_setting = '0;
      if (reg_write && in_region_block)
      begin
         if (sel_field == OFS_START)
            wr_start[sel_idx] = 1'b1;
         else if (sel_field == OFS_SIZE)
            wr_size[sel_idx] = 1'b1;
         else if (sel_field == OFS_REGION_PERMISSION_SETTING)
            wr_region_permission_setting[sel_idx] = 1'b1;
      end
   end

   // Eight independent regions, all compared at once
   generate
      for (genvar g = 0; g < NUM_REGIONS; g++)
      begin : g_region
         frac_region u_region (
            .clk(clk),
            .rst(rst),
            .wr_start(wr_start[g]),
            .wr_size(wr_size[g]),
            .wr_region_permission_setting(wr_region_permission_setting[g]),
            .wdata(reg_wdata),
            .cpu_addr(cpu_addr),
            .dbg_addr(dbg_addr),
            .start(r_start[g]),
            .size(r_size[g]),
            .region_permission_setting(r_region_permission_setting[g]),
            .active(r_active[g]),
            .cpu_rd_blk(cpu_rd_blk[g]),
            .cpu_wr_blk(cpu_wr_blk[g]),
            .dbg_rd_blk(dbg_rd_blk[g]),
            .dbg_wr_blk(dbg_wr_blk[g])
         );
      end
   endgenerate

   // Any matching region with a blocking bit wins; overlaps take the strictest
   assign cpu_is_read = cpu_kind == FRAC_EXEC || cpu_kind == FRAC_READ;
   assign cpu_blocked = cpu_is_read ? |cpu_rd_blk : |cpu_wr_blk;

   // Blocked request never reaches the flash
   assign cpu_flash_en = cpu_req && !cpu_blocked;

   always_ff @(posedge clk)
   begin
      if (rst)
         cpu_bus_fault <= 1'b0;
      else
         cpu_bus_fault <= cpu_req && cpu_blocked;
   end

   // Debugger path: no fault, the access is just neutralised
   assign dbg_rd_blocked = dbg_req && !dbg_write && |dbg_rd_blk;
   assign dbg_wr_blocked = dbg_req && dbg_write && |dbg_wr_blk;
   assign dbg_flash_re = dbg_req && !dbg_write && !dbg_rd_blocked;
   assign dbg_flash_we = dbg_req && dbg_write && !dbg_wr_blocked;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         dbg_read_q <= 1'b0;
         dbg_zero_q <= 1'b0;
      end
      else
      begin
         dbg_read_q <= dbg_req && !dbg_write;
         dbg_zero_q <= dbg_rd_blocked;
      end
   end

   // Flash answers one cycle after the request; result is held in a flop
   always_ff @(posedge clk)
   begin
      if (rst)
         dbg_rdata <= RST_WORD;
      else if (dbg_read_q)
         dbg_rdata <= dbg_zero_q ? RST_WORD : flash_rdata;
   end

   // Events and sticky status
   always_comb
   begin
      events = '0;
      events[EV_CPU_FAULT] = cpu_req && cpu_blocked;
      events[EV_DBG_ZERO] = dbg_rd_blocked;
      events[EV_DBG_DROP] = dbg_wr_blocked;
   end

   // Set wins over a write-one clear in the same cycle
   always_comb
   begin
      next_status = int_status;
      if (reg_write && reg_addr == INT_STATUS)
         next_status = next_status & ~reg_wdata[NUM_EVENTS-1:0];
      next_status = next_status | events;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         int_status <= RST_EVENTS;
      else
         int_status <= next_status;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         int_mask <= RST_EVENTS;
      else if (reg_write && reg_addr == INT_MASK)
         int_mask <= reg_wdata[NUM_EVENTS-1:0];
   end

   assign irq = |(int_status & int_mask);

   // Capture of the most recent violation, CPU taking priority
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         viol_addr <= RST_WORD;
         viol_kind <= FRAC_EXEC;
         viol_src_dbg <= 1'b0;
      end
      else if (cpu_req && cpu_blocked)
      begin
         viol_addr <= cpu_addr;
         viol_kind <= cpu_kind;
         viol_src_dbg <= 1'b0;
      end
      else if (dbg_rd_blocked || dbg_wr_blocked)
      begin
         viol_addr <= dbg_addr;
         viol_kind <= dbg_write ? FRAC_WRITE : FRAC_READ;
         viol_src_dbg <= 1'b1;
      end
   end

   // Saturating count so a flood of faults cannot wrap to a small number
   always_ff @(posedge clk)
   begin
      if (rst)
         viol_cnt <= RST_CNT;
      else if ((cpu_req && cpu_blocked || dbg_rd_blocked || dbg_wr_blocked)
               && viol_cnt != '1)
         viol_cnt <= viol_cnt + 16'h0001;
   end

   // Register read mux
   always_comb
   begin
      next_rdata = RST_WORD;
      if (in_region_block)
      begin
         if (sel_field == OFS_START)
            next_rdata = r_start[sel_idx];
         else if (sel_field == OFS_SIZE)
            next_rdata = r_size[sel_idx];
         else if (sel_field == OFS_REGION_PERMISSION_SETTING)
            next_rdata = {{(DATA_W-REGION_PERMISSION_SETTING_W){1'b0}}, r_region_permission_setting[sel_idx]};
      end
      else if (reg_addr == INT_STATUS)
         next_rdata = {{(DATA_W-NUM_EVENTS){1'b0}}, int_status};
      else if (reg_addr == INT_MASK)
         next_rdata = {{(DATA_W-NUM_EVENTS){1'b0}}, int_mask};
      else if (reg_addr == VIOL_ADDR)
         next_rdata = viol_addr;
      else if (reg_addr == VIOL_INFO)
      begin
         next_rdata[INFO_KIND_LSB +: 2] = viol_kind;
         next_rdata[INFO_SRC_BIT] = viol_src_dbg;
         next_rdata[INFO_CNT_LSB +: CNT_W] = viol_cnt;
      end
      else if (reg_addr == REGION_ACTIVE)
         next_rdata = {{(DATA_W-NUM_REGIONS){1'b0}}, r_active};
   end

   // Read data stand only in the cycle after the strobe
   always_ff @(posedge clk)
   begin
      if (rst)
         reg_rdata <= RST_WORD;
      else if (reg_read)
         reg_rdata <= next_rdata;
      else
         reg_rdata <= RST_WORD;
   end

endmodule

// File: testbench/frac_guard_asserts.sv
// Port-level checks for the flash region guard
`timescale 1ns/1ps
module frac_guard_asserts
   import frac_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [DATA_W-1:0] reg_rdata,
   input wire logic cpu_req,
   input wire logic cpu_flash_en,
   input wire logic cpu_bus_fault,
   input wire logic dbg_req,
   input wire logic dbg_write,
   input wire logic dbg_flash_re,
   input wire logic dbg_flash_we,
   input wire logic [DATA_W-1:0] flash_rdata,
   input wire logic [DATA_W-1:0] dbg_rdata,
   input wire logic irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   a_fault_after_block: assert property (cpu_req && !cpu_flash_en |=> cpu_bus_fault)
      else $error("blocked cpu request gave no fault");
   a_fault_has_cause: assert property (
      cpu_bus_fault |-> $past(cpu_req) && !$past(cpu_flash_en))
      else $error("fault without blocked request");
   a_cpu_enable_cause: assert property (cpu_flash_en |-> cpu_req)
      else $error("cpu flash enable without request");
   a_dbg_read_cause: assert property (dbg_flash_re |-> dbg_req && !dbg_write)
      else $error("debug read enable without read request");
   a_dbg_write_cause: assert property (dbg_flash_we |-> dbg_req && dbg_write)
      else $error("debug write enable without write request");
   a_dbg_read_zero: assert property (
      dbg_req && !dbg_write && !dbg_flash_re |=> ##1 dbg_rdata == 32'h0)
      else $error("blocked debug read not zero");
   a_dbg_read_pass: assert property (
      dbg_req && !dbg_write && dbg_flash_re |=> ##1 dbg_rdata == $past(flash_rdata))
      else $error("allowed debug read lost flash data");
   a_reset_clears: assert property (
      disable iff (1'b0) rst |=> !cpu_bus_fault && !irq && dbg_rdata == 32'h0)
      else $error("outputs not cleared by reset");
   a_reset_opens: assert property (
      $past(rst) && !rst |-> cpu_flash_en == cpu_req
         && dbg_flash_re == (dbg_req && !dbg_write))
      else $error("region still enforced after reset");
   c_cpu_fault: cover property (cpu_bus_fault);
   c_dbg_zero: cover property (dbg_req && !dbg_write && !dbg_flash_re);
   c_dbg_drop: cover property (dbg_req && dbg_write && !dbg_flash_we);
   c_irq: cover property (irq);
endmodule
bind frac_guard frac_guard_asserts u_chk (.clk(clk), .rst(rst), .reg_rdata(reg_rdata),
   .cpu_req(cpu_req), .cpu_flash_en(cpu_flash_en), .cpu_bus_fault(cpu_bus_fault),
   .dbg_req(dbg_req), .dbg_write(dbg_write), .dbg_flash_re(dbg_flash_re),
   .dbg_flash_we(dbg_flash_we), .flash_rdata(flash_rdata), .dbg_rdata(dbg_rdata), .irq(irq));

// File: testbench/frac_flash_model.sv
// Flash array stand-in answering debugger reads one cycle later
`timescale 1ns/1ps
module frac_flash_model
   import frac_pkg::*;
(
   input wire logic clk,
   input wire logic dbg_flash_re,
   input wire logic [ADDR_W-1:0] dbg_addr,
   output logic [DATA_W-1:0] flash_rdata
);
   // Idle data toggles so a stale word never passes for a fresh one
   always_ff @(posedge clk)
   begin
      flash_rdata <= dbg_flash_re ? ~dbg_addr : ~flash_rdata;
   end
endmodule

// File: testbench/flash_region_access_control_tb_top.sv
// Self-checking bench for the flash region guard
`timescale 1ns/1ps
module flash_region_access_control_tb_top
   import frac_pkg::*;
;
   logic clk, rst, reg_write, reg_read, cpu_req, dbg_req, dbg_write;
   logic cpu_flash_en, cpu_bus_fault, dbg_flash_re, dbg_flash_we, irq;
   logic [REG_AW-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata, reg_rdata, flash_rdata, dbg_rdata;
   logic [ADDR_W-1:0] cpu_addr, dbg_addr;
   frac_kind_t cpu_kind;
   int mismatches, check_count;
   // Row: [35] allowed, [34] debugger, [33:32] kind (debugger: [32] write), [31:0] address
   logic [35:0] rows [0:19] = '{36'h8_00001000, 36'h9_00001ffc, 36'h3_00001000, 36'h2_00001ffc,
      36'hb_00002000, 36'h0_00003000, 36'h1_00003ffc, 36'hb_00003000, 36'ha_00003000,
      36'h0_00005000, 36'h3_00006ffc, 36'h9_00007000, 36'hb_00008000, 36'hb_00009004,
      36'ha_00000ffc, 36'hc_00001000, 36'h4_00003000, 36'h5_00001000, 36'hd_00003000,
      36'h4_00005000};

   frac_guard DUT (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .cpu_req(cpu_req),
      .cpu_kind(cpu_kind), .cpu_addr(cpu_addr), .cpu_flash_en(cpu_flash_en),
      .cpu_bus_fault(cpu_bus_fault), .dbg_req(dbg_req), .dbg_write(dbg_write),
      .dbg_addr(dbg_addr), .dbg_flash_re(dbg_flash_re), .dbg_flash_we(dbg_flash_we),
      .flash_rdata(flash_rdata), .dbg_rdata(dbg_rdata), .irq(irq));
   frac_flash_model u_flash (.clk(clk), .dbg_flash_re(dbg_flash_re), .dbg_addr(dbg_addr),
      .flash_rdata(flash_rdata));

   task automatic wrap_up();
      if (mismatches == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk);
      reg_write <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      @(posedge clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk);
      reg_read <= 1'b0;
      #1 chk("reg_rdata", reg_rdata, exp);
   endtask

   task automatic region(input logic [2:0] i, input logic [31:0] s, z, p);
      wr(REGION_BASE + {5'h0, i, OFS_START}, s);
      wr(REGION_BASE + {5'h0, i, OFS_SIZE}, z);
      wr(REGION_BASE + {5'h0, i, OFS_REGION_PERMISSION_SETTING}, p);
   endtask

   task automatic cpu(input frac_kind_t k, input logic [31:0] a, input logic en);
      @(posedge clk);
      cpu_req <= 1'b1;
      cpu_kind <= k;
      cpu_addr <= a;
      #1 chk("cpu_flash_en", {31'h0, cpu_flash_en}, {31'h0, en});
      @(posedge clk);
      cpu_req <= 1'b0;
      #1 chk("cpu_bus_fault", {31'h0, cpu_bus_fault}, {31'h0, !en});
   endtask

   task automatic dbg(input logic w, input logic [31:0] a, input logic en);
      @(posedge clk);
      dbg_req <= 1'b1;
      dbg_write <= w;
      dbg_addr <= a;
      #1 chk("dbg_flash_en", {31'h0, w ? dbg_flash_we : dbg_flash_re}, {31'h0, en});
      @(posedge clk);
      dbg_req <= 1'b0;
      @(posedge clk);
      #1 if (!w) chk("dbg_rdata", dbg_rdata, en ? ~a : 32'h0);
   endtask

   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   initial
   begin
      repeat (4000) @(posedge clk);
      mismatches++;
      wrap_up();
   end

   initial
   begin
      rst = 1'b1;
      {reg_write, reg_read, cpu_req, dbg_req, dbg_write} = 5'h0;
      reg_addr = 12'h0;
      reg_wdata = 32'h0;
      cpu_kind = FRAC_EXEC;
      cpu_addr = 32'h0;
      dbg_addr = 32'h0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      rd(REGION_ACTIVE, 32'h0);
      // Sizes are whole pages; region 3 has no permission, region 4 a bad start
      region(3'h0, 32'h1000, 32'h1000, 32'h2);
      region(3'h1, 32'h3000, 32'h1000, 32'h4);
      region(3'h2, 32'h5000, 32'h2000, 32'h6);
      region(3'h3, 32'h8000, 32'h1000, 32'h0);
      region(3'h4, 32'h9004, 32'h1000, 32'h6);
      rd(REGION_ACTIVE, 32'h07);
      rd(12'h840, 32'h0);
      foreach (rows[i])
      begin
         if (rows[i][34])
            dbg(rows[i][32], rows[i][31:0], rows[i][35]);
         else
            cpu(frac_kind_t'(rows[i][33:32]), rows[i][31:0], rows[i][35]);
      end
      // Access in the cycle right after the last setting, then one cycle on
      region(3'h7, 32'ha000, 32'h1000, 32'h6);
      cpu_req <= 1'b1;
      cpu_kind <= FRAC_EXEC;
      cpu_addr <= 32'ha000;
      #1 chk("cpu_flash_en early", {31'h0, cpu_flash_en}, 32'h1);
      @(posedge clk);
      #1 chk("cpu_flash_en late", {31'h0, cpu_flash_en}, 32'h0);
      @(posedge clk);
      cpu_req <= 1'b0;
      #1 chk("cpu_bus_fault", {31'h0, cpu_bus_fault}, 32'h1);
      rd(REGION_ACTIVE, 32'h87);
      // Rewrites that would open region 0 to writes if they were taken
      region(3'h0, 32'h0, 32'h4000, 32'h4);
      rd(12'h800, 32'h1000);
      rd(12'h804, 32'h1000);
      rd(12'h808, 32'h2);
      cpu(FRAC_WRITE, 32'h1000, 1'b0);
      // Eleven blocked accesses so far, the last a CPU write
      rd(VIOL_ADDR, 32'h1000);
      rd(VIOL_INFO, 32'h000b0003);
      rd(12'h80c, 32'h0);
      rd(12'h200, 32'h0);
      rd(INT_STATUS, 32'h7);
      chk("irq masked", {31'h0, irq}, 32'h0);
      wr(INT_MASK, 32'h1);
      #1 chk("irq", {31'h0, irq}, 32'h1);
      wr(INT_STATUS, 32'h1);
      #1 chk("irq cleared", {31'h0, irq}, 32'h0);
      rd(INT_STATUS, 32'h6);
      wr(INT_MASK, 32'h4);
      #1 chk("irq drop", {31'h0, irq}, 32'h1);
      wr(INT_STATUS, 32'h6);
      #1 chk("irq cleared", {31'h0, irq}, 32'h0);
      // A second reset is the only way back to an open map
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rd(REGION_ACTIVE, 32'h0);
      rd(12'h800, 32'h0);
      cpu(FRAC_EXEC, 32'h5000, 1'b1);
      region(3'h2, 32'h5000, 32'h2000, 32'h6);
      cpu(FRAC_READ, 32'h5000, 1'b0);
      wrap_up();
   end
endmodule
